// [cpu_ctl_pkg.sv]
// How it works
// (RQ1) writing one to sleep bit enters sleep at once
// (RQ2) sleep stops clock, booster, charge pump and transceivers
// (RQ3) counters and timers hold their values during sleep
// (RQ4) enabled wake activity ends sleep; cpu resumes within 0.5 ms
// (RQ5) only writable wake-enable bits wake; two mode bits pick sleep or halt
// (RQ6) writing one to halt bit stops only the cpu
// (RQ7) any enabled, triggered interrupt ends halt; here the breakpoint interrupt does not end halt, only irq_request lines do
// (RQ8) up to two instructions may run after halt before servicing
// (RQ9) software writes zero to reserved bits
// (RQ10) enable bit 12 gates the on-the-go interrupt
// (RQ11) enable bit 11 gates all three spi sources
// (RQ12) enable bit 9 gates all second usb engine sources
// (RQ13) enable bit 8 gates all first usb engine sources
// (RQ14) enable bit 7 gates fast serial port block-done and receive-full
// (RQ15) bits 6 and 5 gate inbound and outbound mailbox
// (RQ16) enable bit 3 gates uart transmit and receive
// (RQ17) bit 2 gates gpio interrupt; clearing it discards pending ones
// (RQ18) bit 1 gates second timer; clearing it discards pending
// (RQ19) bit 0 gates first timer; clearing it discards pending
// (RQ20) breakpoint interrupt when program counter equals breakpoint register
// (RQ21) breakpoint interrupt holds until zero is written to breakpoint register
// (RQ22) request passes only while pending and enabled, including earlier pending
package cpu_ctl_pkg;
  localparam logic [15:0] power_control_addr   = 16'hc00a;
  localparam logic [15:0] int_source_en_addr   = 16'hc00e;
  localparam logic [15:0] pc_breakpoint_addr   = 16'hc014;
  localparam int          halt_bit             = 0;
  localparam int          sleep_bit            = 1;
  localparam int          boost_ok_bit         = 2;
  localparam logic [15:0] power_wr_mask        = 16'h5b93;
  localparam logic [15:0] wake_mask            = 16'h5b90;
  localparam logic [15:0] int_en_wr_mask       = 16'h1bef;
  localparam logic [15:0] reg_reset            = 16'h0000;
  localparam int          en_timer0            = 0;
  localparam int          en_timer1            = 1;
  localparam int          en_gpio              = 2;
  localparam int          en_uart              = 3;
  localparam int          en_mbx_out           = 5;
  localparam int          en_mbx_in            = 6;
  localparam int          en_fast_serial       = 7;
  localparam int          en_usb1              = 8;
  localparam int          en_usb2              = 9;
  localparam int          en_spi               = 11;
  localparam int          en_otg               = 12;
  localparam int          num_groups           = 11;
  localparam int          clk_hz               = 20_000_000;
  localparam int          resume_time_us       = 500;
  localparam int          resume_cycles        = (clk_hz / 1_000_000) * resume_time_us;
  localparam int          halt_slip_max        = 2;
  typedef enum logic [1:0] {run_st, halt_st, sleep_st, wake_st} power_state_e;
endpackage

// [sync2.sv]
`timescale 1ns/1ps
module sync2 import cpu_ctl_pkg::*; #(
  parameter int width = 1
) (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // data
  input  wire logic [width-1:0] d,
  output logic      [width-1:0] q
);
  logic [width-1:0] meta_reg;
  initial begin
    if (width < 1) $error("sync2 width must be positive");
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule

// [irq_gate.sv]
`timescale 1ns/1ps
module irq_gate import cpu_ctl_pkg::*; #(
  parameter bit discard = 1'b0
) (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // source and enable
  input  wire logic event_in,
  input  wire logic enable,
  output logic      request
);
  logic pend_reg;
  logic en_prev_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) en_prev_reg <= 1'b0;
    else en_prev_reg <= enable;
  end
  // discard only on the enable's fall, so a request taken while disabled still
  // passes once enabled; set wins over the discarding clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pend_reg <= 1'b0;
    else if (event_in) pend_reg <= 1'b1;
    else if (discard && en_prev_reg && !enable) pend_reg <= 1'b0; // RQ17 RQ18 RQ19
  end
  assign request = enable & (pend_reg | event_in); // RQ22
endmodule

// [cpu_power_irq_control.sv]
`timescale 1ns/1ps
module cpu_power_irq_control import cpu_ctl_pkg::*; #(
  parameter int resume_count = resume_cycles
) (
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // interrupt sources, pulses or levels from peripherals
  input  wire logic        otg_irq,
  input  wire logic [2:0]  spi_irq,
  input  wire logic [5:0]  usb1_irq,
  input  wire logic [5:0]  usb2_irq,
  input  wire logic [1:0]  fast_serial_port_irq,
  input  wire logic        inbound_mailbox_irq,
  input  wire logic        outbound_mailbox_irq,
  input  wire logic [1:0]  uart_irq,
  input  wire logic        gpio_irq,
  input  wire logic        second_timer_irq,
  input  wire logic        first_timer_irq,
  // wake activity pins, asynchronous
  input  wire logic [15:0] wake_activity,
  input  wire logic        boost_not_ok,
  // processor side
  input  wire logic [15:0] cpu_pc,
  output logic [num_groups-1:0] irq_request,
  output logic             breakpoint_irq,
  output logic             cpu_stop,
  output logic             clock_stop,
  output logic             analog_power_down,
  output logic             counters_hold
);
  logic [15:0] power_reg, int_en_reg, bkpt_reg;
  logic        bkpt_hit_reg;
  logic [15:0] wake_sync, boost_sync;
  logic [31:0] resume_cnt_reg;
  power_state_e state_reg;
  logic        wr_en, rd_en, any_irq, wake_now;
  logic [num_groups-1:0] group_evt, group_en;

  initial begin
    if (resume_count < 1) $error("resume_count must be at least one");
  end

  function automatic logic mapped(input logic [15:0] a);
    return a == power_control_addr || a == int_source_en_addr || a == pc_breakpoint_addr;
  endfunction

  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & penable & ~pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped(paddr);

  sync2 #(.width(16)) wake_sync_i (
    .pclk(pclk), .presetn(presetn), .d(wake_activity), .q(wake_sync));
  sync2 #(.width(16)) boost_sync_i (
    .pclk(pclk), .presetn(presetn), .d({15'h0000, boost_not_ok}), .q(boost_sync));

  // power control: mode bits self-clear when the mode is taken
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) power_reg <= reg_reset;
    else if (wr_en && paddr == power_control_addr) power_reg <= pwdata[15:0] & power_wr_mask;
    else if (state_reg != run_st) power_reg[1:0] <= 2'b00;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) int_en_reg <= reg_reset;
    else if (wr_en && paddr == int_source_en_addr) int_en_reg <= pwdata[15:0] & int_en_wr_mask;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) bkpt_reg <= reg_reset;
    else if (wr_en && paddr == pc_breakpoint_addr) bkpt_reg <= pwdata[15:0];
  end

  // hit sticks until a zero write; a hit in the same cycle still wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) bkpt_hit_reg <= 1'b0;
    else if (bkpt_reg != 16'h0000 && cpu_pc == bkpt_reg) bkpt_hit_reg <= 1'b1; // RQ20
    else if (wr_en && paddr == pc_breakpoint_addr && pwdata[15:0] == 16'h0000)
      bkpt_hit_reg <= 1'b0; // RQ21
  end
  assign breakpoint_irq = bkpt_hit_reg;

  // otg takes the reserved slot so that every enable bit gates a real line
  assign group_evt = {1'b0, |spi_irq, otg_irq, |usb2_irq, |usb1_irq, |fast_serial_port_irq,
                      inbound_mailbox_irq, outbound_mailbox_irq, |uart_irq, gpio_irq,
                      second_timer_irq};
  assign group_en  = {1'b0, int_en_reg[en_spi], int_en_reg[en_otg], // RQ11 RQ10
                      int_en_reg[en_usb2], int_en_reg[en_usb1], // RQ12 RQ13
                      int_en_reg[en_fast_serial], int_en_reg[en_mbx_in], // RQ14 RQ15
                      int_en_reg[en_mbx_out], int_en_reg[en_uart], // RQ15 RQ16
                      int_en_reg[en_gpio], int_en_reg[en_timer1]}; // RQ17 RQ18

  // only gpio and timers lose pending requests when disabled
  genvar g;
  generate
    for (g = 0; g < num_groups - 1; g++) begin : gate_g
      irq_gate #(.discard(g <= 1)) gate_i (
        .pclk(pclk), .presetn(presetn), .event_in(group_evt[g]),
        .enable(group_en[g]), .request(irq_request[g + 1]));
    end
  endgenerate
  irq_gate #(.discard(1'b1)) timer0_gate_i (
    .pclk(pclk), .presetn(presetn), .event_in(first_timer_irq),
    .enable(int_en_reg[en_timer0]), .request(irq_request[0])); // RQ19

  assign any_irq  = |irq_request;
  assign wake_now = |(wake_sync & power_reg & wake_mask); // RQ5

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) state_reg <= run_st;
    else case (state_reg)
      run_st:   if (power_reg[sleep_bit]) state_reg <= sleep_st; // RQ1 RQ5
                else if (power_reg[halt_bit]) state_reg <= halt_st; // RQ6
      halt_st:  if (any_irq) state_reg <= run_st; // RQ7 RQ8
      sleep_st: if (wake_now) state_reg <= wake_st; // RQ4
      wake_st:  if (resume_cnt_reg >= 32'(resume_count - 1)) state_reg <= run_st; // RQ4
      default:  state_reg <= run_st;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) resume_cnt_reg <= 32'h0000_0000;
    else if (state_reg == wake_st) resume_cnt_reg <= resume_cnt_reg + 32'h0000_0001;
    else resume_cnt_reg <= 32'h0000_0000;
  end

  assign cpu_stop          = state_reg != run_st; // RQ6
  assign clock_stop        = state_reg == sleep_st; // RQ2
  assign analog_power_down = state_reg == sleep_st; // RQ2
  assign counters_hold     = state_reg == sleep_st || state_reg == wake_st; // RQ3

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite) begin
      if (paddr == power_control_addr)
        prdata <= {16'h0000, power_reg | {13'h0000, boost_sync[0], 2'b00}};
      else if (paddr == int_source_en_addr) prdata <= {16'h0000, int_en_reg};
      else if (paddr == pc_breakpoint_addr) prdata <= {16'h0000, bkpt_reg};
      else prdata <= 32'h0000_0000;
    end
  end

  sleep_entry_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ1
    state_reg == run_st && power_reg[sleep_bit] |=> clock_stop)
    else $error("sleep not entered");
  halt_exit_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
    state_reg == halt_st && any_irq |=> !cpu_stop)
    else $error("halt not left");
  halt_cpu_only_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ6
    state_reg == halt_st |-> cpu_stop && !clock_stop)
    else $error("halt stopped clock");
  sleep_wake_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ4
    state_reg == wake_st |-> resume_cnt_reg < 32'(resume_count))
    else $error("resume late");
  bkpt_set_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ20
    bkpt_reg != 16'h0000 && cpu_pc == bkpt_reg |=> breakpoint_irq)
    else $error("breakpoint missed");
  bkpt_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ21
    breakpoint_irq && !(wr_en && paddr == pc_breakpoint_addr) |=> breakpoint_irq)
    else $error("breakpoint dropped");
  gate_off_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ22
    !int_en_reg[en_spi] |-> !irq_request[10])
    else $error("disabled request passed");
  timer_discard_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ19
    $fell(int_en_reg[en_timer0]) && !first_timer_irq |=> !timer0_gate_i.pend_reg)
    else $error("timer pending kept");
  hold_sleep_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
    clock_stop |-> counters_hold && analog_power_down)
    else $error("counters not held");
endmodule

// [cpu_model.sv]
`timescale 1ns/1ps
module cpu_model (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // control from the block
  input  wire logic        cpu_stop,
  output logic      [15:0] cpu_pc
);
  // one instruction a cycle; frozen while stopped, no slip modelled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_pc <= 16'h0100;
    end else if (!cpu_stop) begin
      cpu_pc <= cpu_pc + 16'h0001;
    end
  end
endmodule

// [tb_cpu_power_irq_control.sv]
`timescale 1ns/1ps
module tb_cpu_power_irq_control import cpu_ctl_pkg::*; ();
  localparam int RES = 5;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic otg_irq, inbound_mailbox_irq, outbound_mailbox_irq, gpio_irq;
  logic second_timer_irq, first_timer_irq, boost_not_ok, breakpoint_irq;
  logic cpu_stop, clock_stop, analog_power_down, counters_hold;
  logic [2:0] spi_irq;
  logic [5:0] usb1_irq, usb2_irq;
  logic [1:0] fast_serial_port_irq, uart_irq;
  logic [24:0] srcs;
  logic [15:0] paddr, wake_activity, cpu_pc, lf, p, v;
  logic [31:0] pwdata, prdata, rd;
  logic [num_groups-1:0] irq_request;
  int fails, checked, n, i;

  assign {otg_irq, spi_irq, usb1_irq, usb2_irq, fast_serial_port_irq, inbound_mailbox_irq,
          outbound_mailbox_irq, uart_irq, gpio_irq, second_timer_irq, first_timer_irq} = srcs;

  cpu_power_irq_control #(.resume_count(RES)) cpu_power_irq_control_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .otg_irq, .spi_irq, .usb1_irq, .usb2_irq, .fast_serial_port_irq, .inbound_mailbox_irq,
    .outbound_mailbox_irq, .uart_irq, .gpio_irq, .second_timer_irq, .first_timer_irq,
    .wake_activity, .boost_not_ok, .cpu_pc, .irq_request, .breakpoint_irq, .cpu_stop,
    .clock_stop, .analog_power_down, .counters_hold);

  cpu_model cpu_model_i (.pclk, .presetn, .cpu_stop, .cpu_pc);

  function automatic logic [15:0] nx(input logic [15:0] s);
    return s[0] ? ((s >> 1) ^ 16'hb400) : (s >> 1);
  endfunction

  // request lines expected with every source active
  function automatic logic [10:0] gate(input logic [15:0] e);
    return {e[11], e[12], e[9:5], e[3:0]};
  endfunction

  task automatic wrap_up();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic bound(input int k, input int lim);
    if (k >= lim) begin
      fails++;
      $display("ERROR %0t wait ran out", $time);
      wrap_up();
    end
  endtask

  // setup, then access held until pready is seen at an edge
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    bound(k, 20);
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wen(input logic [15:0] e);
    apb(1'b1, int_source_en_addr, {16'h0000, e});
  endtask

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  initial begin
    repeat (20000) @(posedge pclk);
    bound(1, 1);
  end

  initial begin
    presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    srcs = 0; wake_activity = 0; boost_not_ok = 0; fails = 0; checked = 0; lf = 16'd14893;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, int_source_en_addr, 0); chk(rd, 0);
    apb(1'b0, pc_breakpoint_addr, 0); chk(rd, 0);
    apb(1'b0, 16'hc010, 0); chk({err, rd[30:0]}, 32'h80000000);
    // an event taken while disabled, then discarded by clearing the enable
    for (i = 0; i < 3; i++) begin
      srcs[i] <= 1'b1; @(posedge pclk); srcs[i] <= 1'b0; repeat (2) @(posedge pclk);
      chk(irq_request[i], 0);
      wen(16'h0001 << i); chk(irq_request[i], 1);
      wen(0); wen(16'h0001 << i); chk(irq_request[i], 0);
    end
    wen(16'h0001);
    apb(1'b1, power_control_addr, 32'h1);
    @(posedge pclk);
    chk({cpu_stop, clock_stop, counters_hold, analog_power_down}, 4'h8);
    srcs[0] <= 1'b1; @(posedge pclk); srcs[0] <= 1'b0;
    for (n = 0; n < 10 && cpu_stop !== 1'b0; n++) @(posedge pclk);
    bound(n, 10);
    srcs <= '1;
    for (i = 0; i < 14; i++) begin
      lf = nx(lf);
      v = ((i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : lf) & int_en_wr_mask;
      wen(v);
      apb(1'b0, int_source_en_addr, 0); chk(rd, {16'h0000, v});
      chk(irq_request, gate(v));
    end
    srcs <= '0;
    wen(0);
    p = cpu_pc + 16'd40;
    apb(1'b1, pc_breakpoint_addr, {16'h0000, p}); chk(breakpoint_irq, 0);
    for (n = 0; n < 60 && breakpoint_irq !== 1'b1; n++) @(posedge pclk);
    bound(n, 60);
    chk((cpu_pc - p) < 16'd3, 1);
    repeat (30) @(posedge pclk);
    apb(1'b1, pc_breakpoint_addr, {16'h0000, p ^ 16'h8000}); chk(breakpoint_irq, 1);
    apb(1'b1, pc_breakpoint_addr, 0); chk(breakpoint_irq, 0);
    // sleep with only the gpio wake source armed
    apb(1'b1, power_control_addr, 32'h12);
    @(posedge pclk);
    chk({cpu_stop, clock_stop, analog_power_down, counters_hold}, 4'hf);
    wake_activity[7] <= 1'b1; boost_not_ok <= 1'b1; repeat (10) @(posedge pclk);
    chk(clock_stop, 1);
    wake_activity[4] <= 1'b1;
    for (n = 0; n < RES + 12 && cpu_stop !== 1'b0; n++) @(posedge pclk);
    bound(n, RES + 12);
    chk({clock_stop, counters_hold, analog_power_down}, 0);
    apb(1'b0, power_control_addr, 0); chk(rd, 32'h14);
    wrap_up();
  end
endmodule
